// ==== pkg/session_request_params.svh ====
`ifndef SESSION_REQUEST_PARAMS_SVH
`define SESSION_REQUEST_PARAMS_SVH

// Device side: byte-wide register port of the peripheral
`define DEV_REG_SESSION 8'h12
`define DEV_BIT_DUAL_ROLE 0
`define DEV_BIT_SUPPLY_PULSE 1
`define DEV_BIT_DISCHARGE 2
`define DEV_BIT_INIT_VIOL 3
`define DEV_BIT_SESS_VALID 4
`define DEV_BIT_DATA_PULSE 5

// Software side: byte offsets of the 32-bit registers on the Avalon slave
`define CSR_CTRL 4'h0
`define CSR_STATUS 4'h4
`define CSR_LAST 4'h8

`define CTRL_BIT_START 0
`define CTRL_BIT_DISCHARGE 1
`define CTRL_BIT_STOP 2
`define CTRL_RESET 32'h0000_0000

`define STAT_BIT_BUSY 0
`define STAT_BIT_DONE 1
`define STAT_BIT_ABORTED 2
`define STAT_BIT_SESSION 3

// Clock and sequence timing
`define CLK_HZ 200000000
`define INIT_WAIT_MS 3
`define DATA_PULSE_MS 7
`define SUPPLY_PULSE_MS 18
`define DISCHARGE_MS 30
`define READ_SETTLE_CYC 3

`endif

// ==== pkg/session_request_pkg.sv ====
package session_request_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dev_req_s;

    typedef enum logic [13:0] {
        S_IDLE = 14'h0001,
        S_ENABLE = 14'h0002,
        S_CLR_INIT = 14'h0004,
        S_WAIT_INIT = 14'h0008,
        S_READ_INIT = 14'h0010,
        S_DATA_ON = 14'h0020,
        S_DATA_WAIT = 14'h0040,
        S_SUPPLY_ON = 14'h0080,
        S_SUPPLY_WAIT = 14'h0100,
        S_DISCH_ON = 14'h0200,
        S_DISCH_WAIT = 14'h0400,
        S_PULSE_OFF = 14'h0800,
        S_DISABLE = 14'h1000,
        S_READ_SESS = 14'h2000
    } seq_state_e;

endpackage

// ==== src/ms_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Down counter: load a cycle count, expired stays high once it reaches zero
module ms_timer #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic expired
);

    logic [W-1:0] cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign expired = (cnt_ff == '0) && !load;

endmodule // ms_timer

`default_nettype wire

// ==== src/session_request_control.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "session_request_params.svh"

// How it works
// - Clear violation flag, wait over 2 ms, read; one aborts the request.
// - Discharge bit is written zero before session-end detection begins.
// - Supply pulse bit held over 16 ms and cleared before 26 ms.
// - Request is data-line pulsing then supply pulsing; far end sees either.
// - Check violation flag, then hold data-line pulse 5 to 10 ms, clear.
// - After data-line pulsing, hold supply pulse 10 to 20 ms, clear.
// - Optionally discharge the supply for about 30 ms as last step.
// - Supply interrupt mid-request does not cut the pulsing phases short.
// - Session-valid latch is judged with dual-role enable cleared.
// - Both pulsing phases finish within 100 ms in total.
// - On disabling, data-line and supply pulse bits are written with ones.
// - Data-line pulse bit starts pulsing, is cleared when done, resets zero.
module session_request_control
    import session_request_pkg::*;
#(
    parameter int CYC_PER_MS = `CLK_HZ / 1000,
    parameter int INIT_WAIT_CYC = `INIT_WAIT_MS * CYC_PER_MS,
    parameter int DATA_PULSE_CYC = `DATA_PULSE_MS * CYC_PER_MS,
    parameter int SUPPLY_PULSE_CYC = `SUPPLY_PULSE_MS * CYC_PER_MS,
    parameter int DISCHARGE_CYC = `DISCHARGE_MS * CYC_PER_MS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output dev_req_s dev_req,
    input wire logic [7:0] dev_rdata
);

    // Timer width covers the longest wait at the full clock rate
    localparam int TW = 32;
    localparam logic [2:0] SETTLE = 3'(`READ_SETTLE_CYC);

    seq_state_e state_ff;
    seq_state_e nxt_state;
    dev_req_s req_ff;
    logic discharge_opt_ff;
    logic done_ff;
    logic aborted_ff;
    logic session_ff;
    logic [7:0] last_ff;
    logic [31:0] readdata_ff;
    logic rd_ack_ff;
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] sync3_ff;
    logic [2:0] settle_ff;
    logic timer_load;
    logic [TW-1:0] timer_val;
    logic timer_expired;
    logic start_req;
    logic stop_req;
    logic status_clr;
    logic read_ok;
    logic finish;
    logic abort_flag_ff;

    // Device register images for each step of the sequence
    localparam logic [7:0] EN = 8'h01 << `DEV_BIT_DUAL_ROLE;
    localparam logic [7:0] IV = 8'h01 << `DEV_BIT_INIT_VIOL;
    localparam logic [7:0] DP = 8'h01 << `DEV_BIT_DATA_PULSE;
    localparam logic [7:0] SP = 8'h01 << `DEV_BIT_SUPPLY_PULSE;
    localparam logic [7:0] DC = 8'h01 << `DEV_BIT_DISCHARGE;

    // Start is a self-clearing command bit, refused while a sequence runs
    assign start_req = avs_write && (avs_address == `CSR_CTRL)
        && avs_writedata[`CTRL_BIT_START];
    assign stop_req = avs_write && (avs_address == `CSR_CTRL)
        && avs_writedata[`CTRL_BIT_STOP];
    // Only the done bit has a write-one clear
    assign status_clr = avs_write && (avs_address == `CSR_STATUS)
        && avs_writedata[`STAT_BIT_DONE];

    // Device read data arrives from pins: three stages, accept once stable
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            sync3_ff <= 8'h00;
        end else begin
            sync1_ff <= dev_rdata;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            settle_ff <= 3'h0;
        end else if (!req_ff.rd) begin
            settle_ff <= 3'h0;
        end else if (settle_ff != SETTLE) begin
            settle_ff <= settle_ff + 3'h1;
        end
    end

    // A byte counts only after settling and once stages two and three agree
    assign read_ok = req_ff.rd && (settle_ff == SETTLE) && (sync2_ff == sync3_ff);

    // All millisecond figures are cycle counts scaled by CYC_PER_MS
    ms_timer #(
        .W(TW)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(timer_load),
        .load_val(timer_val),
        .expired(timer_expired)
    );

    always_comb begin
        nxt_state = state_ff;
        timer_load = 1'b0;
        timer_val = '0;
        finish = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start_req) begin
                    nxt_state = S_ENABLE;
                end
            end
            S_ENABLE: nxt_state = S_CLR_INIT;
            S_CLR_INIT: begin
                nxt_state = S_WAIT_INIT;
                timer_load = 1'b1;
                timer_val = TW'(INIT_WAIT_CYC);
            end
            S_WAIT_INIT: begin
                if (timer_expired) begin
                    nxt_state = S_READ_INIT;
                end
            end
            S_READ_INIT: begin
                if (read_ok) begin
                    // Flag still set means the supply or lines were not quiet
                    nxt_state = sync3_ff[`DEV_BIT_INIT_VIOL] ? S_DISABLE : S_DATA_ON;
                end
            end
            S_DATA_ON: begin
                nxt_state = S_DATA_WAIT;
                timer_load = 1'b1;
                timer_val = TW'(DATA_PULSE_CYC);
            end
            S_DATA_WAIT: begin
                if (timer_expired) begin
                    nxt_state = S_SUPPLY_ON;
                end
            end
            S_SUPPLY_ON: begin
                nxt_state = S_SUPPLY_WAIT;
                timer_load = 1'b1;
                timer_val = TW'(SUPPLY_PULSE_CYC);
            end
            S_SUPPLY_WAIT: begin
                // Supply events are ignored here; only a software stop cuts the phases short
                if (timer_expired) begin
                    nxt_state = discharge_opt_ff ? S_DISCH_ON : S_PULSE_OFF;
                end
            end
            S_DISCH_ON: begin
                nxt_state = S_DISCH_WAIT;
                timer_load = 1'b1;
                timer_val = TW'(DISCHARGE_CYC);
            end
            S_DISCH_WAIT: begin
                if (timer_expired) begin
                    nxt_state = S_PULSE_OFF;
                end
            end
            S_PULSE_OFF: nxt_state = S_DISABLE;
            // Abort path returns to idle without checking the session
            S_DISABLE: nxt_state = abort_flag_ff ? S_IDLE : S_READ_SESS;
            S_READ_SESS: begin
                if (read_ok) begin
                    nxt_state = S_IDLE;
                    finish = 1'b1;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
        // Stop is refused once the disable write or the session read has begun
        if (stop_req && (state_ff != S_IDLE) && (state_ff != S_DISABLE)
            && (state_ff != S_READ_SESS)) begin
            nxt_state = S_DISABLE;
            timer_load = 1'b0;
        end
    end

    // Abort path: violation seen, or software stop, skips the session check

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            abort_flag_ff <= 1'b0;
        end else if (state_ff == S_IDLE) begin
            abort_flag_ff <= 1'b0;
        end else if ((state_ff == S_READ_INIT) && read_ok
            && sync3_ff[`DEV_BIT_INIT_VIOL]) begin
            abort_flag_ff <= 1'b1;
        end else if (stop_req && (state_ff != S_DISABLE)
            && (state_ff != S_READ_SESS)) begin
            abort_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One write pulse on entry to each write state; read held until settled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_ff <= '0;
        end else begin
            req_ff.addr <= `DEV_REG_SESSION;
            req_ff.wr <= 1'b0;
            // Read strobe drops in the cycle after the byte is accepted
            req_ff.rd <= ((nxt_state == S_READ_INIT) || (nxt_state == S_READ_SESS))
                && !read_ok;
            case (nxt_state)
                S_ENABLE: begin
                    req_ff.wr <= (state_ff != S_ENABLE);
                    req_ff.wdata <= EN;
                end
                S_CLR_INIT: begin
                    req_ff.wr <= (state_ff != S_CLR_INIT);
                    req_ff.wdata <= EN | IV;
                end
                S_DATA_ON: begin
                    req_ff.wr <= 1'b1;
                    req_ff.wdata <= EN | DP;
                end
                S_SUPPLY_ON: begin
                    req_ff.wr <= 1'b1;
                    req_ff.wdata <= EN | SP;
                end
                S_DISCH_ON: begin
                    req_ff.wr <= 1'b1;
                    req_ff.wdata <= EN | DC;
                end
                S_PULSE_OFF: begin
                    req_ff.wr <= 1'b1;
                    req_ff.wdata <= EN;
                end
                // Enable drops here; ones in the pulse bits clear them on the way out
                S_DISABLE: begin
                    req_ff.wr <= (state_ff != S_DISABLE);
                    req_ff.wdata <= DP | SP;
                end
                default: begin
                    req_ff.wdata <= req_ff.wdata;
                end
            endcase
        end
    end

    assign dev_req = req_ff;

    // Discharge option is stored and consulted when the supply phase ends
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            discharge_opt_ff <= 1'b0;
        end else if (avs_write && (avs_address == `CSR_CTRL)) begin
            discharge_opt_ff <= avs_writedata[`CTRL_BIT_DISCHARGE];
        end
    end

    // Last byte read is kept so software can see why a request was aborted
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            last_ff <= 8'h00;
        end else if (read_ok) begin
            last_ff <= sync3_ff;
        end
    end

    // Done is sticky; a finishing sequence beats a clear in the same cycle
    logic end_event;
    assign end_event = finish || ((state_ff == S_DISABLE) && abort_flag_ff);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
            aborted_ff <= 1'b0;
            session_ff <= 1'b0;
        end else if (end_event) begin
            done_ff <= 1'b1;
            aborted_ff <= abort_flag_ff;
            session_ff <= finish && sync3_ff[`DEV_BIT_SESS_VALID];
        end else if (status_clr) begin
            done_ff <= 1'b0;
        // Aborted and session stay readable until the next accepted start
        end else if (start_req && (state_ff == S_IDLE)) begin
            aborted_ff <= 1'b0;
            session_ff <= 1'b0;
        end
    end

    // Reads take one wait cycle so read data come from a register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_ack_ff <= 1'b0;
            readdata_ff <= 32'h0;
        end else begin
            rd_ack_ff <= avs_read && !rd_ack_ff;
            if (avs_read && !rd_ack_ff) begin
                case (avs_address)
                    `CSR_CTRL: readdata_ff <= {30'h0, discharge_opt_ff, 1'b0};
                    `CSR_STATUS: readdata_ff <= {28'h0, session_ff, aborted_ff,
                        done_ff, (state_ff != S_IDLE)};
                    `CSR_LAST: readdata_ff <= {24'h0, last_ff};
                    default: readdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign avs_readdata = readdata_ff;
    assign avs_waitrequest = avs_read && !rd_ack_ff;

endmodule // session_request_control

`default_nettype wire

// ==== sim/session_request_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module session_request_control_asserts
    import session_request_pkg::*;
#(
    parameter int CYC_PER_MS = 200000
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dev_req_s dev_req,
    input wire logic [7:0] dev_rdata
);
    logic [7:0] last_ff;
    logic [31:0] gap_ff;
    logic wr;

    assign wr = dev_req.wr;

    // Gap counts cycles since the previous device write, so hold times are judged at the next one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            last_ff <= 8'h00;
            gap_ff <= 32'h0;
        end else if (wr) begin
            last_ff <= dev_req.wdata;
            gap_ff <= 32'h0;
        end else begin
            gap_ff <= gap_ff + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_wr_no_rd: assert property (!(dev_req.wr && dev_req.rd))
        else $error("device write and read together");
    chk_dev_addr: assert property ((dev_req.wr || dev_req.rd) |-> dev_req.addr == 8'h12)
        else $error("device access to wrong register");
    chk_init_gap: assert property (wr && dev_req.wdata == 8'h21 |->
        last_ff == 8'h09 && gap_ff > 2 * CYC_PER_MS)
        else $error("data pulse started without a settled violation check");
    chk_data_hold: assert property (
        wr && last_ff == 8'h21 && dev_req.wdata[0] |->
        dev_req.wdata == 8'h03 && gap_ff >= 5 * CYC_PER_MS && gap_ff <= 10 * CYC_PER_MS)
        else $error("data pulse phase wrong");
    chk_supply_hold: assert property (
        wr && last_ff == 8'h03 && dev_req.wdata[0] |->
        gap_ff > 16 * CYC_PER_MS && gap_ff <= 20 * CYC_PER_MS)
        else $error("supply pulse held for wrong time");
    chk_supply_next: assert property (
        wr && last_ff == 8'h03 && dev_req.wdata[0] |->
        dev_req.wdata == 8'h05 || dev_req.wdata == 8'h01)
        else $error("supply pulse not ended properly");
    chk_disch_off: assert property (wr && last_ff == 8'h05 |-> dev_req.wdata == 8'h01)
        else $error("discharge not cleared first");
    chk_disable_ones: assert property (wr && !dev_req.wdata[0] |->
        dev_req.wdata[5] && dev_req.wdata[1])
        else $error("disable write without ones in pulse bits");
    chk_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered in its first cycle");
    chk_rd_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read answer late");
    chk_wr_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");

    cov_data: cover property (wr && dev_req.wdata == 8'h21);
    cov_disch: cover property (wr && dev_req.wdata == 8'h05);
    cov_abort: cover property (wr && last_ff == 8'h09 && dev_req.wdata == 8'h22);
endmodule // session_request_control_asserts

bind session_request_control session_request_control_asserts #(
    .CYC_PER_MS(CYC_PER_MS)
) u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .dev_req(dev_req),
    .dev_rdata(dev_rdata)
);

`default_nettype wire

// ==== sim/srp_device_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// No interrupt output: supply side effects are not modelled
module srp_device_model
    import session_request_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dev_req_s dev_req,
    input wire logic cond_unmet,
    input wire logic sess_valid,
    output logic [7:0] dev_rdata,
    output logic [7:0] state,
    output logic [15:0] dp_cycles,
    output logic [15:0] vp_cycles,
    output logic [15:0] dc_cycles
);
    logic [7:0] reg_ff;
    logic [7:0] last_ff;
    logic hit;

    assign hit = dev_req.wr && dev_req.addr == 8'h12;
    assign state = reg_ff;
    // Released bus shows the inverse of the last byte, so stale data cannot pass
    assign dev_rdata = dev_req.rd ? reg_ff : ~last_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_ff <= 8'h00;
        end else begin
            if (hit) begin
                reg_ff[0] <= dev_req.wdata[0];
                // Control bits are masked while dual-role enable is low
                reg_ff[1] <= dev_req.wdata[0] & dev_req.wdata[1];
                reg_ff[2] <= dev_req.wdata[0] & dev_req.wdata[2];
                reg_ff[5] <= dev_req.wdata[0] & dev_req.wdata[5];
            end
            // Write one clears; a standing condition sets the flag again at once
            reg_ff[3] <= cond_unmet | (reg_ff[3] & ~(hit & dev_req.wdata[3]));
            reg_ff[4] <= sess_valid | (reg_ff[4] & ~(hit & dev_req.wdata[4]));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            last_ff <= 8'h00;
            dp_cycles <= 16'h0;
            vp_cycles <= 16'h0;
            dc_cycles <= 16'h0;
        end else begin
            if (dev_req.rd) begin
                last_ff <= reg_ff;
            end
            dp_cycles <= dp_cycles + 16'(reg_ff[5]);
            vp_cycles <= vp_cycles + 16'(reg_ff[1]);
            dc_cycles <= dc_cycles + 16'(reg_ff[2]);
        end
    end
endmodule // srp_device_model

`default_nettype wire

// ==== sim/session_request_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module session_request_control_tb;
    import session_request_pkg::*;
    localparam int C = 10;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    dev_req_s dev_req;
    logic [7:0] dev_rdata;
    logic cond_unmet = 1'b0;
    logic sess_valid = 1'b0;
    logic [7:0] state;
    logic [15:0] dp_cycles;
    logic [15:0] vp_cycles;
    logic [15:0] dc_cycles;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] q;

    always #2.5 ref_clk = ~ref_clk;

    session_request_control #(.CYC_PER_MS(C)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dev_req(dev_req), .dev_rdata(dev_rdata));
    srp_device_model u_dev (.ref_clk(ref_clk), .rst_n(rst_n), .dev_req(dev_req),
        .cond_unmet(cond_unmet), .sess_valid(sess_valid), .dev_rdata(dev_rdata),
        .state(state), .dp_cycles(dp_cycles), .vp_cycles(vp_cycles), .dc_cycles(dc_cycles));

    task automatic summarize();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Request is held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q & m, e);
    endtask

    task automatic do_reset(input logic unmet, input logic valid);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cond_unmet <= unmet;
        sess_valid <= valid;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    task automatic run(input logic [31:0] ctrl);
        int n;
        n = 0;
        bus(1'b1, 4'h0, ctrl);
        repeat (2) @(posedge ref_clk);
        do begin
            bus(1'b0, 4'h4, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic t_reset();
        do_reset(1'b0, 1'b0);
        rd_chk(4'h0, 32'hffffffff, 32'h0);
        rd_chk(4'h4, 32'hffffffff, 32'h0);
        rd_chk(4'h8, 32'hffffffff, 32'h0);
        rd_chk(4'hc, 32'hffffffff, 32'h0);
    endtask

    task automatic t_session();
        do_reset(1'b0, 1'b1);
        run(32'h1);
        rd_chk(4'h4, 32'hf, 32'ha);
        rd_chk(4'h8, 32'hff, 32'h10);
        check(32'(state), 32'h10);
        check(32'(dp_cycles >= 16'(5 * C) && dp_cycles <= 16'(10 * C)), 32'h1);
        check(32'(vp_cycles > 16'(16 * C) && vp_cycles <= 16'(20 * C)), 32'h1);
        check(32'(dp_cycles + vp_cycles < 16'(100 * C)), 32'h1);
        check(32'(dc_cycles), 32'h0);
        bus(1'b1, 4'h4, 32'h2);
        rd_chk(4'h4, 32'h2, 32'h0);
    endtask

    task automatic t_violation();
        do_reset(1'b1, 1'b0);
        run(32'h1);
        rd_chk(4'h4, 32'hf, 32'h6);
        rd_chk(4'h8, 32'hff, 32'h09);
        check(32'(dp_cycles), 32'h0);
        check(32'(state), 32'h08);
    endtask

    task automatic t_discharge();
        do_reset(1'b0, 1'b0);
        bus(1'b1, 4'h0, 32'h2);
        rd_chk(4'h0, 32'h7, 32'h2);
        run(32'h3);
        rd_chk(4'h4, 32'hf, 32'h2);
        check(32'(dc_cycles >= 16'(30 * C)), 32'h1);
        check(32'(state), 32'h0);
        rd_chk(4'h8, 32'hff, 32'h0);
    endtask

    task automatic t_stop();
        do_reset(1'b0, 1'b0);
        bus(1'b1, 4'h0, 32'h1);
        repeat (150) @(posedge ref_clk);
        bus(1'b1, 4'h0, 32'h4);
        run(32'h0);
        rd_chk(4'h4, 32'h5, 32'h4);
        check(32'(state & 8'h22), 32'h0);
    endtask

    initial begin
        t_reset();
        t_session();
        t_violation();
        t_discharge();
        t_stop();
        summarize();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
endmodule // session_request_control_tb

`default_nettype wire
